// file: psl_port_regs.sv
// Port error status and link capabilities registers on the configuration access port.
// Assumes configuration accesses and error events on the core clock; strap and aux
// power pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
module psl_port_regs (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  // Configuration access port, word aligned byte addresses.
  input  wire logic [7:0]         cfg_addr_in,
  input  wire logic               cfg_wr_in,
  input  wire logic               cfg_rd_in,
  input  wire logic [3:0]         cfg_be_in,
  input  wire logic [31:0]        cfg_wdata_in,
  output logic      [31:0]        cfg_rdata_out,
  output logic                    cfg_rvalid_out,
  // Error detection events from the port's transaction logic.
  input  wire psl_pkg::psl_err_s  err_detect_in,
  // Strap and power pins.
  input  wire psl_pkg::psl_strap_s strap_in,
  // Start-up loader from the serial management bus or EEPROM engine.
  input  wire logic               load_valid_in,
  input  wire psl_pkg::psl_caps_s load_caps_in,
  output logic                    init_done_out,
  // Register contents toward the rest of the port.
  output logic      [3:0]         report_en_out,
  output psl_pkg::psl_err_s       err_flags_out,
  output psl_pkg::psl_caps_s      link_caps_out
);

  // Defaults that depend on which port this is and how the switch is strapped.
  function automatic psl_pkg::psl_caps_s default_caps(input psl_pkg::psl_strap_s s);
    psl_pkg::psl_caps_s c;
    c = '0;
    c.speed = psl_pkg::RST_SPEED;
    c.width = (s.upstream && s.x4_mode) ? psl_pkg::WIDTH_X4 : psl_pkg::WIDTH_X1;
    c.aspm = psl_pkg::RST_ASPM;
    c.l0s_exit = psl_pkg::RST_L0S_EXIT;
    c.l1_exit = psl_pkg::RST_L1_EXIT;
    c.clk_pm = psl_pkg::RST_CLK_PM_UP;
    c.surprise = psl_pkg::RST_SURPRISE;
    c.dll_active = psl_pkg::RST_DLL_DOWN;
    case (s.port_idx)
      3'h0: c.port_num = psl_pkg::PORT_NUM_P0;
      3'h1: c.port_num = psl_pkg::PORT_NUM_P1;
      3'h2: c.port_num = psl_pkg::PORT_NUM_P2;
      3'h3: c.port_num = psl_pkg::PORT_NUM_P3;
      3'h4: c.port_num = psl_pkg::PORT_NUM_P4;
      3'h5: c.port_num = psl_pkg::PORT_NUM_P5;
      default: c.port_num = psl_pkg::PORT_NUM_P0;
    endcase
    return c;
  endfunction

  // Forces the hardwired fields, whatever the defaults or a loader asked for.
  // Speed and width are not loadable: speed is always the reset code, and width always comes from the straps.
  function automatic psl_pkg::psl_caps_s enforce_caps(input psl_pkg::psl_caps_s c_in,
                                                      input psl_pkg::psl_strap_s s);
    psl_pkg::psl_caps_s c;
    psl_pkg::psl_caps_s dflt;
    c = c_in;
    dflt = default_caps(s);
    c.speed = dflt.speed;
    c.width = dflt.width;
    c.rsvd = '0;
    c.bw_notify = psl_pkg::BW_NOTIFY_VAL;
    if (!s.upstream) begin
      c.clk_pm = 1'b0;
    end
    if (s.upstream) begin
      c.dll_active = 1'b0;
    end else if (s.hotplug) begin
      c.dll_active = 1'b1;
    end
    return c;
  endfunction

  psl_pkg::psl_strap_s strap_sync;
  psl_pkg::psl_strap_s strap_q;
  psl_pkg::psl_init_e  init_q;
  psl_pkg::psl_init_e  init_d;
  logic [1:0]          settle_q;
  psl_pkg::psl_caps_s  caps_q;
  logic [3:0]          report_en_q;
  logic                aux_q;
  logic [3:0]          flags;
  logic [3:0]          flag_clr;
  logic                hit_status;
  logic                hit_caps;
  logic [31:0]         rdata_q;
  logic                rvalid_q;
  logic                init_done_q;

  psl_sync #(
    .W ($bits(psl_pkg::psl_strap_s))
  ) u_strap_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   (strap_in),
    .sync_out   (strap_sync)
  );

  assign hit_status = (cfg_addr_in == psl_pkg::OFF_ERR_STATUS);
  assign hit_caps   = (cfg_addr_in == psl_pkg::OFF_LINK_CAPS);

  // Start-up sequence: wait for synchronised straps, apply defaults, then accept loads.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      settle_q <= 2'h0;
    end else if (init_q == psl_pkg::ST_SETTLE) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  always_comb begin
    init_d = init_q;
    case (init_q)
      psl_pkg::ST_SETTLE: begin
        if (settle_q == psl_pkg::STRAP_SETTLE) begin
          init_d = psl_pkg::ST_APPLY;
        end
      end
      psl_pkg::ST_APPLY: begin
        init_d = psl_pkg::ST_RUN;
      end
      psl_pkg::ST_RUN: begin
        init_d = psl_pkg::ST_RUN;
      end
      default: begin
        init_d = psl_pkg::ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      init_q <= psl_pkg::ST_SETTLE;
    end else begin
      init_q <= init_d;
    end
  end

  // Straps are latched once at the apply step so later pin glitches cannot move the port.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      strap_q <= '0;
    end else if (init_q == psl_pkg::ST_APPLY) begin
      strap_q <= strap_sync;
    end
  end

  // Aux power follows its pin continuously once the synchroniser has settled.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      aux_q <= psl_pkg::RST_AUX_POWER;
    end else if (init_q != psl_pkg::ST_SETTLE) begin
      aux_q <= strap_sync.aux_power;
    end
  end

  // Capability word: constant reset, strap defaults at apply, loader overrides after.
  // Configuration writes never reach this register.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      caps_q <= '0;
      caps_q.speed <= psl_pkg::RST_SPEED;
      caps_q.width <= psl_pkg::WIDTH_X1;
      caps_q.l0s_exit <= psl_pkg::RST_L0S_EXIT;
      caps_q.l1_exit <= psl_pkg::RST_L1_EXIT;
    end else if (init_q == psl_pkg::ST_APPLY) begin
      caps_q <= enforce_caps(default_caps(strap_sync), strap_sync);
    end else if (init_q == psl_pkg::ST_RUN && load_valid_in) begin
      caps_q <= enforce_caps(load_caps_in, strap_q);
    end
  end

  // Reporting enables in the low byte of the status word.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      report_en_q <= psl_pkg::RST_REPORT_EN;
    end else if (cfg_wr_in && hit_status && cfg_be_in[0]) begin
      report_en_q <= cfg_wdata_in[psl_pkg::POS_REPORT_EN +: 4];
    end
  end

  // Only ones in the flag byte clear, and only when that byte lane is written.
  assign flag_clr = (cfg_wr_in && hit_status && cfg_be_in[2]) ?
                    cfg_wdata_in[psl_pkg::POS_ERR_FLAGS +: 4] : 4'h0;

  // Error events feed the flags directly; the enables play no part in logging.
  psl_sticky_bank #(
    .W (4)
  ) u_err_flags (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .set_in     (err_detect_in),
    .clr_in     (flag_clr),
    .flag_out   (flags)
  );

  // Read data one cycle after the request; unmapped offsets return zero.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cfg_rd_in;
      if (cfg_rd_in && hit_status) begin
        rdata_q <= {10'h000, psl_pkg::TXN_PEND_VALUE, aux_q, flags, 12'h000,
                    report_en_q};
      end else if (cfg_rd_in && hit_caps) begin
        rdata_q <= caps_q;
      end else if (cfg_rd_in) begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= (init_d == psl_pkg::ST_RUN);
    end
  end

  assign cfg_rdata_out  = rdata_q;
  assign cfg_rvalid_out = rvalid_q;
  assign init_done_out  = init_done_q;
  assign report_en_out  = report_en_q;
  assign err_flags_out  = flags;
  assign link_caps_out  = caps_q;

endmodule // psl_port_regs

// file: psl_pkg.sv
// Constants, field layouts and types for the port error status and link capabilities registers.
// Assumes a single core clock with a synchronous active-low port reset.
// Notes on behaviour
// - Correctable (16) and non-fatal (17) flags set on detection, cleared by writing one.
// - Fatal (18) and unsupported request (19) flags likewise; both reset to zero.
// - All four flags log errors whatever the reporting enables say.
// - Bit 20 shows detected auxiliary power, read-only, one after reset.
// - Transactions pending bit 21 always reads zero.
// - Maximum link speed in bits 3:0, read-only, resets to 5.0 Gb/s code.
// - Maximum width bits 9:4: x4 for four-lane upstream, otherwise x1.
// - Power management support bits 11:10 read-only, reset to 00b.
// - Standby exit latency bits 14:12 reset to 011b, 256 to 512 ns.
// - Deep low-power exit latency bits 17:15 reset to 000b, 16 to 32 us.
// - Clock removal tolerance bit 18 is one upstream, held zero downstream.
// - Loadable capability defaults may be replaced by the start-up loaders.
// - Link-active reporting bit 20 is one downstream, held zero upstream.
// - A hot-plug capable downstream port always reports link-active reporting as one.
// - Bandwidth notification bit 21 is zero on every port.
// - Port number bits 31:24 per port; port 1 defaults to 02h as port 2.
// - Four reporting enables in the control half-word, each resetting to zero.
package psl_pkg;

  localparam logic [7:0]  OFF_ERR_STATUS = 8'hc8;
  localparam logic [7:0]  OFF_LINK_CAPS  = 8'hcc;

  // Field positions inside the word at the status offset.
  localparam int          POS_REPORT_EN  = 0;
  localparam int          POS_ERR_FLAGS  = 16;
  localparam int          POS_AUX_POWER  = 20;
  localparam int          POS_TXN_PEND   = 21;

  localparam logic [3:0]  RST_REPORT_EN  = 4'h0;
  localparam logic [3:0]  RST_ERR_FLAGS  = 4'h0;
  localparam logic        RST_AUX_POWER  = 1'b1;
  localparam logic        TXN_PEND_VALUE = 1'b0;

  localparam logic [3:0]  SPEED_2G5      = 4'h1;
  localparam logic [3:0]  SPEED_5G0      = 4'h2;
  localparam logic [3:0]  RST_SPEED      = SPEED_5G0;
  localparam logic [5:0]  WIDTH_X4       = 6'h04;
  localparam logic [5:0]  WIDTH_X1       = 6'h01;
  localparam logic [1:0]  RST_ASPM       = 2'h0;
  localparam logic [2:0]  RST_L0S_EXIT   = 3'h3;
  localparam logic [2:0]  RST_L1_EXIT    = 3'h0;
  localparam logic        RST_CLK_PM_UP  = 1'b1;
  localparam logic        RST_SURPRISE   = 1'b0;
  localparam logic        RST_DLL_DOWN   = 1'b1;
  localparam logic        BW_NOTIFY_VAL  = 1'b0;

  localparam logic [7:0]  PORT_NUM_P0    = 8'h00;
  localparam logic [7:0]  PORT_NUM_P1    = 8'h02;
  localparam logic [7:0]  PORT_NUM_P2    = 8'h02;
  localparam logic [7:0]  PORT_NUM_P3    = 8'h03;
  localparam logic [7:0]  PORT_NUM_P4    = 8'h04;
  localparam logic [7:0]  PORT_NUM_P5    = 8'h05;

  // Edges after reset release before synchronised straps are trusted.
  localparam logic [1:0]  STRAP_SETTLE   = 2'h2;

  typedef struct packed {
    logic       unsupported;
    logic       fatal;
    logic       nonfatal;
    logic       correctable;
  } psl_err_s;

  typedef struct packed {
    logic [7:0] port_num;
    logic [1:0] rsvd;
    logic       bw_notify;
    logic       dll_active;
    logic       surprise;
    logic       clk_pm;
    logic [2:0] l1_exit;
    logic [2:0] l0s_exit;
    logic [1:0] aspm;
    logic [5:0] width;
    logic [3:0] speed;
  } psl_caps_s;

  typedef struct packed {
    logic [2:0] port_idx;
    logic       upstream;
    logic       x4_mode;
    logic       hotplug;
    logic       aux_power;
  } psl_strap_s;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_APPLY  = 2'b01,
    ST_RUN    = 2'b10
  } psl_init_e;

endpackage

// file: psl_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are quasi-static levels; multi-bit values are not coherent while changing.
`timescale 1ns/1ps
module psl_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // psl_sync

// file: psl_sticky_bank.sv
// Bank of sticky flags that hardware sets and software clears by writing one.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module psl_sticky_bank #(
  parameter int W = 4
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output logic      [W-1:0] flag_out
);

  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  // Set is applied after clear so an event in the clearing cycle survives.
  assign flag_d = (flag_q & ~clr_in) | set_in;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;

endmodule // psl_sticky_bank

// file: psl_port_regs_assertions.sv
// Checker for the port register block, bound to its top module.
// Assumes straps change only while reset is held low.
`timescale 1ns/1ps
module psl_port_regs_assertions (
  input wire logic                sys_clk_in,
  input wire logic                rst_n_in,
  input wire logic [7:0]          cfg_addr_in,
  input wire logic                cfg_wr_in,
  input wire logic                cfg_rd_in,
  input wire logic [3:0]          cfg_be_in,
  input wire logic [31:0]         cfg_wdata_in,
  input wire logic [31:0]         cfg_rdata_out,
  input wire logic                cfg_rvalid_out,
  input wire psl_pkg::psl_err_s   err_detect_in,
  input wire psl_pkg::psl_strap_s strap_in,
  input wire logic                load_valid_in,
  input wire logic                init_done_out,
  input wire logic [3:0]          report_en_out,
  input wire psl_pkg::psl_err_s   err_flags_out,
  input wire psl_pkg::psl_caps_s  link_caps_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire       st_wr = cfg_wr_in && cfg_addr_in == 8'hc8;
  wire [3:0] clr_m = (st_wr && cfg_be_in[2]) ? cfg_wdata_in[19:16] : 4'h0;

  property p_err_set;
    |err_detect_in |=> (err_flags_out & $past(err_detect_in)) == $past(err_detect_in);
  endproperty
  a_err_set: assert property (p_err_set) else $error("flag missed");
  property p_err_clr;
    |clr_m |=> (err_flags_out & $past(clr_m) & ~$past(err_detect_in)) == 4'h0;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("flag not cleared");
  property p_err_keep;
    1'b1 |=> (err_flags_out & $past(err_flags_out) & ~$past(clr_m))
             == ($past(err_flags_out) & ~$past(clr_m));
  endproperty
  a_err_keep: assert property (p_err_keep) else $error("flag lost");
  property p_rd_status;
    cfg_rd_in && cfg_addr_in == 8'hc8 |=> cfg_rvalid_out && cfg_rdata_out[31:21] == 11'h0
      && cfg_rdata_out[15:4] == 12'h0 && cfg_rdata_out[19:16] == $past(err_flags_out);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("bad status read");
  property p_rd_unmap;
    cfg_rd_in && cfg_addr_in != 8'hc8 && cfg_addr_in != 8'hcc
      |=> cfg_rvalid_out && cfg_rdata_out == 32'h0000_0000;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
  property p_caps_fixed;
    link_caps_out.speed == psl_pkg::SPEED_5G0 && !link_caps_out.bw_notify
      && link_caps_out.rsvd == 2'h0;
  endproperty
  a_caps_fixed: assert property (p_caps_fixed) else $error("fixed caps");
  property p_caps_strap;
    init_done_out |-> link_caps_out.width == ((strap_in.upstream && strap_in.x4_mode)
      ? psl_pkg::WIDTH_X4 : psl_pkg::WIDTH_X1) && (strap_in.upstream
      ? !link_caps_out.dll_active
      : (!link_caps_out.clk_pm && (link_caps_out.dll_active || !strap_in.hotplug)));
  endproperty
  a_caps_strap: assert property (p_caps_strap) else $error("strap caps");
  property p_caps_hold;
    init_done_out && !load_valid_in |=> $stable(link_caps_out);
  endproperty
  a_caps_hold: assert property (p_caps_hold) else $error("caps changed");
  property p_en_wr;
    st_wr && cfg_be_in[0] |=> report_en_out == $past(cfg_wdata_in[3:0]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable write");
  c_clr_race: cover property (|clr_m && |err_detect_in);
  c_load: cover property (load_valid_in && init_done_out);
  c_en: cover property (st_wr && cfg_be_in[0]);
endmodule // psl_port_regs_assertions

bind psl_port_regs psl_port_regs_assertions psl_port_regs_assertions_inst (.sys_clk_in,
  .rst_n_in, .cfg_addr_in, .cfg_wr_in, .cfg_rd_in, .cfg_be_in, .cfg_wdata_in, .cfg_rdata_out,
  .cfg_rvalid_out, .err_detect_in, .strap_in, .load_valid_in, .init_done_out, .report_en_out,
  .err_flags_out, .link_caps_out);

// file: psl_far_model.sv
// Far-side model: error sources, strap pins and the start-up loader.
// Drives its outputs just after a falling edge of the core clock.
`timescale 1ns/1ps
module psl_far_model (
  input  wire logic          sys_clk_in,
  output psl_pkg::psl_err_s   err_out,
  output psl_pkg::psl_strap_s strap_out,
  output logic               load_valid_out,
  output psl_pkg::psl_caps_s  load_caps_out
);
  initial begin
    err_out = '0;
    strap_out = '0;
    load_valid_out = 1'b0;
    load_caps_out = '0;
  end
  task automatic fire(input logic [3:0] e);
    @(negedge sys_clk_in) err_out = e;
    @(negedge sys_clk_in) err_out = '0;
  endtask
  task automatic load(input logic [31:0] c);
    @(negedge sys_clk_in) load_valid_out = 1'b1;
    load_caps_out = c;
    @(negedge sys_clk_in) load_valid_out = 1'b0;
    // An idle loader bus must not look like the last word.
    load_caps_out = ~c;
  endtask
endmodule // psl_far_model

// file: tb_pcie_port_status_link_caps.sv
// Self-checking bench for the port error status and link capabilities registers.
// Assumes the far-side model supplies errors, straps and loader words.
`timescale 1ns/1ps
module tb_pcie_port_status_link_caps;
  logic                sys_clk_in = 1'b0;
  logic                rst_n_in = 1'b0;
  logic [7:0]          cfg_addr_in = 8'h00;
  logic                cfg_wr_in = 1'b0;
  logic                cfg_rd_in = 1'b0;
  logic [3:0]          cfg_be_in = 4'h0;
  logic [31:0]         cfg_wdata_in = 32'h0000_0000;
  logic [31:0]         cfg_rdata_out;
  logic                cfg_rvalid_out;
  psl_pkg::psl_err_s   err_detect_in;
  psl_pkg::psl_strap_s strap_in;
  logic                load_valid_in;
  psl_pkg::psl_caps_s  load_caps_in;
  logic                init_done_out;
  logic [3:0]          report_en_out;
  psl_pkg::psl_err_s   err_flags_out;
  psl_pkg::psl_caps_s  link_caps_out;
  int                  err_total = 0;
  int                  checked = 0;

  always #2.5 sys_clk_in = ~sys_clk_in;

  psl_port_regs psl_port_regs_inst (.sys_clk_in, .rst_n_in, .cfg_addr_in, .cfg_wr_in,
    .cfg_rd_in, .cfg_be_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out, .err_detect_in,
    .strap_in, .load_valid_in, .load_caps_in, .init_done_out, .report_en_out,
    .err_flags_out, .link_caps_out);
  psl_far_model psl_far_model_inst (.sys_clk_in, .err_out(err_detect_in),
    .strap_out(strap_in), .load_valid_out(load_valid_in), .load_caps_out(load_caps_in));

  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic [6:0] s);
    int n;
    @(negedge sys_clk_in) rst_n_in = 1'b0;
    psl_far_model_inst.strap_out = s;
    repeat (10) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    n = 0;
    while (init_done_out !== 1'b1) begin
      @(negedge sys_clk_in);
      n++;
      if (n > 50) begin
        err_total++;
        conclude();
      end
    end
  endtask
  // A read is answered one cycle after it is taken, so it is judged there.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(negedge sys_clk_in) cfg_addr_in = a;
    cfg_rd_in = 1'b1;
    @(negedge sys_clk_in) cfg_rd_in = 1'b0;
    chk(cfg_rvalid_out ? cfg_rdata_out : 32'hdead_beef, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge sys_clk_in) cfg_addr_in = a;
    cfg_be_in = b;
    cfg_wdata_in = d;
    cfg_wr_in = 1'b1;
    @(negedge sys_clk_in) cfg_wr_in = 1'b0;
    cfg_wdata_in = ~d;
  endtask
  function automatic logic [31:0] caps(input logic [6:0] s);
    psl_pkg::psl_strap_s t;
    logic [7:0]          pn;
    t = s;
    pn = (t.port_idx == 3'h1) ? 8'h02 : {5'h00, t.port_idx};
    caps = {pn, 3'h0, !t.upstream, 1'h0, t.upstream, 3'h0, 3'h3, 2'h0,
            (t.upstream && t.x4_mode) ? 6'h04 : 6'h01, 4'h2};
  endfunction

  task automatic t_straps;
    logic [6:0] s;
    for (int i = 0; i < 6; i++) begin
      s = {i[2:0], i < 2, i == 0, i[0], 1'h1};
      do_reset(s);
      rdc(8'hcc, caps(s));
      rdc(8'hc8, 32'h0010_0000);
      wr(8'hcc, 4'hf, 32'hffff_ffff);
      rdc(8'hcc, caps(s));
      rdc(8'hc4, 32'h0000_0000);
    end
    psl_far_model_inst.load(32'h0000_0000);
    rdc(8'hcc, 32'h0010_0012);
    $display("t_straps done");
  endtask
  task automatic t_load;
    do_reset({3'h4, 1'h1, 1'h0, 1'h0, 1'h1});
    psl_far_model_inst.load(32'hffff_ffff);
    rdc(8'hcc, 32'hff0f_fc12);
    chk(link_caps_out, 32'hff0f_fc12);
    $display("t_load done");
  endtask
  task automatic t_errors;
    chk({28'h000_0000, report_en_out}, 32'h0000_0000);
    psl_far_model_inst.fire(4'hf);
    rdc(8'hc8, 32'h001f_0000);
    wr(8'hc8, 4'h4, 32'h0000_0000);
    rdc(8'hc8, 32'h001f_0000);
    wr(8'hc8, 4'hb, 32'h0005_0000);
    rdc(8'hc8, 32'h001f_0000);
    wr(8'hc8, 4'h4, 32'hffff_ffff);
    rdc(8'hc8, 32'h0010_0000);
    fork
      psl_far_model_inst.fire(4'h2);
      wr(8'hc8, 4'h4, 32'h0002_0000);
    join
    rdc(8'hc8, 32'h0012_0000);
    wr(8'hc8, 4'h1, 32'hffff_ffff);
    rdc(8'hc8, 32'h0012_000f);
    @(negedge sys_clk_in) psl_far_model_inst.strap_out.aux_power = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    rdc(8'hc8, 32'h0002_000f);
    $display("t_errors done");
  endtask
  // The aux pin is low here, so only the reset value can make bit 20 read one early on.
  task automatic t_aux_reset;
    @(negedge sys_clk_in) rst_n_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    rdc(8'hc8, 32'h0010_0000);
    repeat (6) @(negedge sys_clk_in);
    chk({31'h0000_0000, init_done_out}, 32'h0000_0001);
    rdc(8'hc8, 32'h0000_0000);
    $display("t_aux_reset done");
  endtask

  initial begin
    t_straps();
    t_load();
    t_errors();
    t_aux_reset();
    conclude();
  end
endmodule // tb_pcie_port_status_link_caps
